// File: core/alarm_router_pkg.sv
`default_nettype none
package alarm_router_pkg;
    // ***************************************************************
    // sizes and register offsets
    // ***************************************************************
    localparam int unsigned NUM_LINES = 4;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_POL = 8'h04;
    localparam logic [7:0] OFS_POL_CMD = 8'h08;
    localparam logic [7:0] OFS_MODE = 8'h0c;
    localparam logic [7:0] OFS_CLEAR = 8'h10;
    localparam logic [7:0] OFS_MAP = 8'h14;
    localparam logic [7:0] OFS_RB = 8'h18;
    localparam logic [7:0] OFS_CH_ID = 8'h1c;
    localparam logic [7:0] OFS_STATE = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int unsigned CMD_FACTORY = 0;
    localparam int unsigned CMD_SCAN = 1;
    localparam int unsigned CMD_CLR_ALL = 2;
    localparam int unsigned POLCMD_ALL = 2;
    localparam int unsigned POLCMD_HIGH = 3;
    localparam int unsigned MAP_LINE_LSB = 8;
    localparam int unsigned MAP_EN = 12;
    localparam int unsigned RB_VALID = 8;
    // ***************************************************************
    // reset values and response codes
    // ***************************************************************
    localparam logic [3:0] POL_RST = 4'h0;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [1:0] MAP_LINE_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ***************************************************************
    // readback characters
    // ***************************************************************
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_OPEN = 8'h28;
    localparam logic [7:0] CH_CLOSE = 8'h29;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_ZERO = 8'h30;
    typedef enum logic [8:0] {
        PH_HASH = 9'h001, PH_LEN = 9'h002, PH_CNT = 9'h004,
        PH_OPEN = 9'h008, PH_AT = 9'h010, PH_CH = 9'h020,
        PH_COMMA = 9'h040, PH_CLOSE = 9'h080, PH_DONE = 9'h100
    } rb_phase_t;
    typedef struct packed {
        logic valid;
        logic [7:0] ch;
        logic alarm;
    } reading_t;
endpackage : alarm_router_pkg
`default_nettype wire

// File: core/alarm_output_router.sv
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`default_nettype none
module alarm_output_router #(
    parameter int unsigned SLOTS = 3,
    parameter int unsigned CH_PER_SLOT = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // axi4-lite slave
    input wire logic [alarm_router_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [alarm_router_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // readings from the limit comparator
    input wire alarm_router_pkg::reading_t reading_i,
    // outputs
    output logic [3:0] alarm_pin_o,
    output logic limits_clear_o,
    output logic irq_o
);
    import alarm_router_pkg::*;
    localparam int unsigned NUM_CH = SLOTS * CH_PER_SLOT;
    localparam int unsigned CH_W = $clog2(NUM_CH);
    // ***************************************************************
    // bus slave
    // ***************************************************************
    logic aw_hold, w_hold, bvalid, rvalid;
    logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data, rdata, next_rdata;
    logic [3:0] w_strb, next_w_strb;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic wr_go, wr_en, rd_go, w_hit, r_hit;
    logic [31:0] rd_val;
    // ***************************************************************
    // configuration and alarm state
    // ***************************************************************
    logic [3:0] pol, mode, line_act, alarm_data, irq_stat, irq_mask, pin;
    logic [3:0] next_pol, next_mode, next_line_act, next_alarm_data;
    logic [3:0] next_irq_stat, next_irq_mask, next_pin, clr_line, ev;
    logic [1:0] map_line [NUM_CH];
    logic [1:0] next_map_line [NUM_CH];
    logic [NUM_CH-1:0] map_en, next_map_en;
    logic [7:0] map_sel, next_map_sel;
    logic limits_clear, next_limits_clear, factory, map_dirty;
    logic [1:0] rl;
    // ***************************************************************
    // mapping readback
    // ***************************************************************
    rb_phase_t ph, next_ph;
    logic [1:0] rb_line, next_rb_line;
    logic [CH_W-1:0] rb_idx, next_rb_idx, found_idx;
    logic [1:0] rb_dig, next_rb_dig;
    logic [7:0] rb_char, cnt_len, n_map;
    logic rb_adv, found, cnt_two;
    logic [11:0] sel_id;

    // channel index to slot digit and two-digit number
    function automatic logic [11:0] ch_id(input int unsigned idx);
        int unsigned num;
        num = idx % CH_PER_SLOT + 1;
        ch_id = {4'((idx / CH_PER_SLOT) + 1), 4'(num / 10), 4'(num % 10)};
    endfunction : ch_id

    assign s_axi_awready_o = !aw_hold;
    assign s_axi_wready_o = !w_hold;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign wr_go = aw_hold && w_hold && !bvalid;
    // partial strobes are answered but ignored: no field is split usefully
    assign wr_en = wr_go && w_hit && (&w_strb);
    assign rd_go = s_axi_arvalid_i && !rvalid;
    assign rb_adv = rd_go && (s_axi_araddr_i == OFS_RB);
    assign factory = wr_en && (aw_addr == OFS_CMD) && w_data[CMD_FACTORY];
    assign sel_id = ch_id(int'(map_sel));

    always_comb begin
        w_hit = 1'b1;
        case (aw_addr)
            OFS_CMD, OFS_POL, OFS_POL_CMD, OFS_MODE, OFS_CLEAR, OFS_MAP,
            OFS_RB, OFS_IRQ_STAT, OFS_IRQ_MASK: w_hit = 1'b1;
            default: w_hit = 1'b0;
        endcase
        r_hit = 1'b1;
        rd_val = 32'h0;
        case (s_axi_araddr_i)
            OFS_POL: rd_val = {28'h0, pol};
            OFS_MODE: rd_val = {28'h0, mode};
            OFS_MAP: rd_val = {19'h0, map_en[map_sel[CH_W-1:0]], 1'b0, 1'b0,
                map_line[map_sel[CH_W-1:0]], map_sel};
            OFS_RB: rd_val = {23'h0, ph != PH_DONE, rb_char};
            OFS_CH_ID: rd_val = {20'h0, sel_id};
            OFS_STATE: rd_val = {24'h0, alarm_data, line_act};
            OFS_IRQ_STAT: rd_val = {28'h0, irq_stat};
            OFS_IRQ_MASK: rd_val = {28'h0, irq_mask};
            OFS_CMD, OFS_POL_CMD, OFS_CLEAR: rd_val = 32'h0;
            default: r_hit = 1'b0;
        endcase
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold = w_hold;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid_i && !aw_hold) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_hold) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = w_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rdata = rd_val;
            next_rresp = r_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_hold <= 1'b0;
            aw_addr <= 8'h0;
            w_hold <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    always_comb begin
        next_pol = pol;
        next_mode = mode;
        next_map_line = map_line;
        next_map_en = map_en;
        next_map_sel = map_sel;
        next_line_act = line_act;
        next_alarm_data = alarm_data;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_limits_clear = 1'b0;
        clr_line = 4'h0;
        ev = 4'h0;
        map_dirty = 1'b0;
        rl = map_line[reading_i.ch[CH_W-1:0]];
        if (wr_en) begin
            case (aw_addr)
                OFS_POL: next_pol = w_data[3:0];
                OFS_POL_CMD: begin
                    if (w_data[POLCMD_ALL]) begin
                        next_pol = {4{w_data[POLCMD_HIGH]}};
                    end else begin
                        next_pol[w_data[1:0]] = w_data[POLCMD_HIGH];
                    end
                end
                OFS_MODE: next_mode = w_data[3:0];
                OFS_CLEAR: clr_line = w_data[3:0];
                OFS_MAP: begin
                    next_map_sel = w_data[7:0];
                    if (w_data[7:0] < 8'(NUM_CH)) begin
                        // one line field per channel, so a single mapping
                        next_map_line[w_data[CH_W-1:0]] = w_data[MAP_LINE_LSB+:2];
                        next_map_en[w_data[CH_W-1:0]] = w_data[MAP_EN];
                    end
                end
                OFS_IRQ_MASK: next_irq_mask = w_data[3:0];
                OFS_CMD: begin
                    if (w_data[CMD_CLR_ALL]) begin
                        clr_line = 4'hf;
                    end
                    if (w_data[CMD_SCAN]) begin
                        clr_line = 4'hf;
                        next_alarm_data = 4'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        next_line_act = next_line_act & ~clr_line;
        if (reading_i.valid && reading_i.ch < 8'(NUM_CH)
                && map_en[reading_i.ch[CH_W-1:0]]) begin
            if (reading_i.alarm) begin
                ev[rl] = 1'b1;
            end else if (mode[rl]) begin
                next_line_act[rl] = 1'b0;
            end
        end
        // a new alarm wins over a clear in the same cycle
        next_line_act = next_line_act | ev;
        next_alarm_data = next_alarm_data | ev;
        if (wr_en && aw_addr == OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~w_data[3:0];
        end
        next_irq_stat = next_irq_stat | (ev & ~line_act);
        if (factory) begin
            next_pol = POL_RST;
            next_mode = MODE_RST;
            next_line_act = 4'h0;
            next_limits_clear = 1'b1;
            for (int i = 0; i < NUM_CH; i++) begin
                next_map_line[i] = MAP_LINE_RST;
            end
            next_map_en = '0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            map_dirty = map_dirty | (map_line[i] != MAP_LINE_RST);
        end
        // pin follows the new polarity and state together
        next_pin = ~(next_pol ^ next_line_act);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pol <= POL_RST;
            mode <= MODE_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                map_line[i] <= MAP_LINE_RST;
            end
            map_en <= '0;
            map_sel <= 8'h0;
            line_act <= 4'h0;
            alarm_data <= 4'h0;
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
            limits_clear <= 1'b0;
            pin <= ~POL_RST;
        end else begin
            pol <= next_pol;
            mode <= next_mode;
            map_line <= next_map_line;
            map_en <= next_map_en;
            map_sel <= next_map_sel;
            line_act <= next_line_act;
            alarm_data <= next_alarm_data;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            limits_clear <= next_limits_clear;
            pin <= next_pin;
        end
    end

    assign alarm_pin_o = pin;
    assign limits_clear_o = limits_clear;
    assign irq_o = |(irq_stat & irq_mask);

    always_comb begin
        n_map = 8'h0;
        found = 1'b0;
        found_idx = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            n_map = n_map + 8'(map_line[i] == rb_line);
            if (!found && map_line[i] == rb_line
                    && (ph == PH_AT || CH_W'(i) > rb_idx)) begin
                found = 1'b1;
                found_idx = CH_W'(i);
            end
        end
        // count of characters in "(@id,id,...)"
        cnt_len = (n_map == 8'h0) ? 8'h3 : 8'((n_map << 2) + 8'h2);
        cnt_two = cnt_len >= 8'h0a;
        rb_char = 8'h0;
        case (ph)
            PH_HASH: rb_char = CH_HASH;
            PH_LEN: rb_char = CH_ZERO + (cnt_two ? 8'h2 : 8'h1);
            PH_CNT: rb_char = CH_ZERO + ((cnt_two && rb_dig == 2'h0) ?
                8'(cnt_len / 10) : 8'(cnt_len % 10));
            PH_OPEN: rb_char = CH_OPEN;
            PH_AT: rb_char = CH_AT;
            PH_CH: rb_char = CH_ZERO + 8'(4'(ch_id(int'(rb_idx)) >> (4 * (2 - rb_dig))));
            PH_COMMA: rb_char = CH_COMMA;
            PH_CLOSE: rb_char = CH_CLOSE;
            default: rb_char = 8'h0;
        endcase
        next_ph = ph;
        next_rb_line = rb_line;
        next_rb_idx = rb_idx;
        next_rb_dig = rb_dig;
        if (rb_adv) begin
            next_rb_dig = 2'h0;
            case (ph)
                PH_HASH: next_ph = PH_LEN;
                PH_LEN: next_ph = PH_CNT;
                PH_CNT: begin
                    next_rb_dig = rb_dig + 2'h1;
                    if (!cnt_two || rb_dig != 2'h0) begin
                        next_ph = PH_OPEN;
                        next_rb_dig = 2'h0;
                    end
                end
                PH_OPEN: next_ph = PH_AT;
                PH_AT, PH_COMMA: begin
                    next_ph = found ? PH_CH : PH_CLOSE;
                    next_rb_idx = found ? found_idx : rb_idx;
                end
                PH_CH: begin
                    next_rb_dig = rb_dig + 2'h1;
                    if (rb_dig == 2'h2) begin
                        next_rb_dig = 2'h0;
                        next_ph = found ? PH_COMMA : PH_CLOSE;
                    end
                end
                PH_CLOSE: next_ph = PH_DONE;
                default: next_ph = PH_DONE;
            endcase
        end
        if (wr_en && aw_addr == OFS_RB) begin
            next_ph = PH_HASH;
            next_rb_line = w_data[1:0];
            next_rb_idx = '0;
            next_rb_dig = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph <= PH_DONE;
            rb_line <= 2'h0;
            rb_idx <= '0;
            rb_dig <= 2'h0;
        end else begin
            ph <= next_ph;
            rb_line <= next_rb_line;
            rb_idx <= next_rb_idx;
            rb_dig <= next_rb_dig;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_PIN_ENCODE: assert property (alarm_pin_o == ~(pol ^ line_act))
        else $error("pin level does not match polarity and state");
    AST_POL_ALL: assert property (wr_en && aw_addr == OFS_POL_CMD
        && w_data[POLCMD_ALL] && !factory
        |=> pol == {4{$past(w_data[POLCMD_HIGH])}})
        else $error("polarity write to all lines missed a line");
    AST_FACTORY_CFG: assert property (factory |=> pol == 4'h0 && mode == 4'h0
        && line_act == 4'h0 && limits_clear_o && alarm_pin_o == 4'hf)
        else $error("factory reset left polarity, mode or lines");
    AST_FACTORY_MAP: assert property (factory |=> !map_dirty && map_en == '0)
        else $error("factory reset left a mapping or enable");
    AST_POL_READ: assert property (rd_go && s_axi_araddr_i == OFS_POL
        |=> s_axi_rvalid_o && s_axi_rdata_o[3:0] == $past(pol))
        else $error("polarity readback wrong");
    AST_TRIGGER: assert property (reading_i.valid && reading_i.alarm
        && reading_i.ch < 8'(NUM_CH) && map_en[reading_i.ch[CH_W-1:0]] && !factory
        |=> line_act[$past(rl)])
        else $error("alarm reading did not raise its line");
    // every line resets to hold mode, so any mapped line exercises it until MODE sets its bit
    AST_HOLD: assert property ((line_act & ~mode & ~clr_line) != 4'h0
        && !factory
        |=> ($past(line_act & ~mode & ~clr_line) & ~line_act) == 4'h0)
        else $error("hold line dropped without a clear");
    AST_FOLLOW: assert property (reading_i.valid && !reading_i.alarm
        && reading_i.ch < 8'(NUM_CH) && map_en[reading_i.ch[CH_W-1:0]] && mode[rl]
        |=> !line_act[$past(rl)])
        else $error("follow line stayed active within limits");
    AST_CLEAR_KEEP: assert property (wr_en && aw_addr == OFS_CLEAR
        |=> (line_act & $past(w_data[3:0] & ~ev)) == 4'h0
        && alarm_data == ($past(alarm_data) | $past(ev)))
        else $error("clear lost alarm data or left a line");
endmodule : alarm_output_router
`default_nettype wire

// File: verification/alarm_pin_monitor.sv
`default_nettype none
module alarm_pin_monitor (
    // pins and polarity in use
    input wire logic [3:0] pin_i,
    input wire logic [3:0] pol_i,
    // decoded alarm per line
    output logic [3:0] active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // a set polarity bit means the line signals by going high
    assign active_o = ~(pin_i ^ pol_i);
endmodule : alarm_pin_monitor
`default_nettype wire

// File: verification/alarm_output_router_tb.sv
`default_nettype none
module alarm_output_router_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import alarm_router_pkg::*;
    // ************
    // signals
    // ************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, lclr;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pins, act;
    logic [3:0] pol = 4'h0;
    reading_t rdn = '0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int fail_count = 0, num_checks = 0, lc_cnt = 0, lc0;
    int seed = 32'h4b123dec;
    string s = "#16(@101)";
    alarm_output_router DUT (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .reading_i(rdn),
        .alarm_pin_o(pins), .limits_clear_o(lclr), .irq_o(irq));
    alarm_pin_monitor PEER (.pin_i(pins), .pol_i(pol), .active_o(act));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // ************
    // tasks
    // ************
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // ready lines stay high, so a valid cycle is always a completed response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            // only release what is still offered, so a next call never double drives
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
    endtask : rd
    task automatic rdg(input logic [7:0] ch, input logic al);
        rdn <= '{1'b1, ch, al};
        @(posedge sys_clk);
        rdn <= '0;
        @(posedge sys_clk);
    endtask : rdg
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    always @(posedge sys_clk) begin
        if (rvalid) check({rresp, rdata}, rq.pop_front());
        if (bvalid) check({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (lclr) lc_cnt++;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        test_done();
    end
    // ************
    // scenarios
    // ************
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check(act, 4'h0);
        rd(OFS_POL, 32'h0, RESP_OKAY);
        rd(OFS_MODE, 32'h0, RESP_OKAY);
        rd(OFS_MAP, 32'h0, RESP_OKAY);
        rd(OFS_CH_ID, 32'h101, RESP_OKAY);
        repeat (8) rdg(8'({$random(seed)} % 24), 1'b1);
        check(act, 4'h0);
        wr(OFS_MAP, 32'h1200, RESP_OKAY);
        rd(OFS_MAP, 32'h1200, RESP_OKAY);
        rdg(8'h00, 1'b1);
        check(act, 4'h4);
        rdg(8'h00, 1'b0);
        check(act, 4'h4);
        rd(OFS_STATE, 32'h44, RESP_OKAY);
        rd(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
        check(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h4, RESP_OKAY);
        check(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
        check(irq, 1'b0);
        wr(OFS_CLEAR, 32'h4, RESP_OKAY);
        check(act, 4'h0);
        rd(OFS_STATE, 32'h40, RESP_OKAY);
        wr(OFS_RB, 32'h2, RESP_OKAY);
        for (int i = 0; i < s.len(); i++) rd(OFS_RB, {23'h0, 1'b1, s[i]}, RESP_OKAY);
        rd(OFS_RB, 32'h0, RESP_OKAY);
        wr(OFS_POL_CMD, 32'hc, RESP_OKAY);
        pol = 4'hf;
        rd(OFS_POL, 32'hf, RESP_OKAY);
        check(pins, 4'h0);
        wr(OFS_POL_CMD, 32'h1, RESP_OKAY);
        pol = 4'hd;
        rd(OFS_POL, 32'hd, RESP_OKAY);
        wr(OFS_MODE, 32'h4, RESP_OKAY);
        rdg(8'h00, 1'b1);
        check(pins, 4'h6);
        wr(OFS_POL_CMD, 32'h2, RESP_OKAY);
        pol = 4'h9;
        check(pins, 4'h2);
        rdg(8'h00, 1'b0);
        check(act, 4'h0);
        rdg(8'h00, 1'b1);
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        check(act, 4'h0);
        rd(OFS_STATE, 32'h0, RESP_OKAY);
        wr(8'h3c, 32'h1, RESP_SLVERR);
        lc0 = lc_cnt;
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        pol = 4'h0;
        repeat (3) @(posedge sys_clk);
        check(34'(lc_cnt - lc0), 34'h1);
        rd(OFS_POL, 32'h0, RESP_OKAY);
        rd(OFS_MODE, 32'h0, RESP_OKAY);
        rd(OFS_MAP, 32'h0, RESP_OKAY);
        rdg(8'h00, 1'b1);
        check(pins, 4'hf);
        wr(OFS_POL, 32'h5, RESP_OKAY);
        pol = 4'h5;
        rd(OFS_POL, 32'h5, RESP_OKAY);
        wr(OFS_MAP, 32'h1200, RESP_OKAY);
        rdg(8'h00, 1'b1);
        check(act, 4'h4);
        wr(OFS_CMD, 32'h4, RESP_OKAY);
        check(act, 4'h0);
        rd(OFS_STATE, 32'h40, RESP_OKAY);
        rdg(8'h00, 1'b1);
        check(act, 4'h4);
        // mid-run power cycle with a held line
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        pol = 4'h0;
        @(posedge sys_clk);
        check(pins, 4'hf);
        rd(OFS_STATE, 32'h0, RESP_OKAY);
        rd(OFS_POL, 32'h0, RESP_OKAY);
        test_done();
    end
endmodule : alarm_output_router_tb
`default_nettype wire
